// *** dv/asr_ctrl_assertions.sv ***
`timescale 1ns/10ps
module asr_ctrl_assertions #(
    parameter int RD_CYCLES = asr_pkg::RD_CYC,
    parameter int WR_CYCLES = asr_pkg::WR_CYC
) (
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic                       req_valid,
    input wire logic                       req_ready,
    input wire asr_pkg::asr_req_t          req,
    input wire logic                       rsp_valid,
    input wire logic [asr_pkg::ADDR_W-1:0] mem_addr,
    input wire asr_pkg::asr_strobe_t       mem_strobe,
    input wire logic [asr_pkg::DATA_W-1:0] mem_dq_out,
    input wire logic [1:0]                 mem_dq_oe_n
);
    localparam int RSP_D = RD_CYCLES + 2;
    logic [7:0] low_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk)
        low_cnt <= (rst || mem_strobe.write_n) ? 8'h00 : low_cnt + 8'h01;
    no_contend_a: assert property (!mem_strobe.out_en_n |-> mem_dq_oe_n == 2'b11)
        else $error("data driven during read");
    read_mode_a: assert property (!mem_strobe.out_en_n |-> mem_strobe.write_n)
        else $error("read enable with write strobe");
    wr_drive_a: assert property (!mem_strobe.write_n |-> !mem_strobe.chip_sel_n &&
        mem_dq_oe_n == {mem_strobe.upper_lane_sel_n, mem_strobe.lower_lane_sel_n})
        else $error("write lanes and drive differ");
    wr_width_a: assert property ($rose(mem_strobe.write_n) |-> low_cnt == WR_CYCLES)
        else $error("write pulse width wrong");
    wr_end_a: assert property ($rose(mem_strobe.write_n) |-> mem_strobe == 5'h1F)
        else $error("strobes did not end together");
    wr_hold_a: assert property ($rose(mem_strobe.write_n) |-> $stable(mem_dq_out) &&
        $stable(mem_dq_oe_n)) else $error("write data not held");
    addr_setup_a: assert property ($fell(mem_strobe.chip_sel_n) |-> $stable(mem_addr))
        else $error("address moved with select");
    rsp_time_a: assert property (req_valid && req_ready && !req.write &&
        req.lane_en != 2'b00 |-> ##RSP_D rsp_valid) else $error("read answer late");
    no_access_a: assert property (req_valid && req_ready && req.lane_en == 2'b00
        |=> mem_strobe.chip_sel_n [*3]) else $error("access without lanes");
    cover property (rsp_valid);
    cover property ($rose(mem_strobe.write_n));
    cover property (req_valid && req_ready && req.lane_en == 2'b00);
endmodule
bind asr_ctrl asr_ctrl_assertions #(.RD_CYCLES(RD_CYCLES), .WR_CYCLES(WR_CYCLES))
    i_asr_ctrl_assertions (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .mem_addr(mem_addr),
    .mem_strobe(mem_strobe), .mem_dq_out(mem_dq_out), .mem_dq_oe_n(mem_dq_oe_n));

// *** dv/asr_ctrl_bench.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module asr_ctrl_bench;
    logic                        clk, rst, clk_en, req_valid, req_ready, rsp_valid;
    asr_pkg::asr_req_t           req;
    asr_pkg::asr_strobe_t        mem_strobe;
    logic [asr_pkg::ADDR_W-1:0]  mem_addr;
    logic [15:0]                 rsp_rdata, mem_dq_in, mem_dq_out, q;
    logic [1:0]                  mem_dq_oe_n;
    int                          n_mismatch, cmp_count;
    asr_ctrl i_asr_ctrl (.clk(clk),
        .rst(rst), .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
        .mem_strobe(mem_strobe), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out),
        .mem_dq_oe_n(mem_dq_oe_n));
    asr_sram_model i_asr_sram_model (.addr(mem_addr), .strobe(mem_strobe),
        .dq_out(mem_dq_out), .dq_oe_n(mem_dq_oe_n), .dq_in(mem_dq_in));
    task automatic stop_test;
        $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Bounded wait on ready (sel low) or on the read answer (sel high)
    task automatic wait_hi(input logic sel);
        int i;
        for (i = 0; i < 60 && (sel ? rsp_valid : req_ready) !== 1'b1; i++)
            @(posedge clk) #1;
        if (i == 60)
        begin
            n_mismatch++;
            stop_test;
        end
    endtask
    // One request held until taken; a read also waits for its answer
    task automatic xfer(input logic w, input logic [17:0] a, input logic [1:0] ln,
                        input logic [15:0] d);
        req_valid = 1'b1;
        req = '{w, a, ln, d};
        wait_hi(1'b0);
        @(posedge clk) #1;
        req_valid = 1'b0;
        if (!w)
        begin
            wait_hi(1'b1);
            q = rsp_rdata;
        end
        else
            @(posedge clk) #1;
    endtask
    task automatic t_full;
        xfer(1'b1, 18'h3_FFFF, 2'b11, 16'hA5C3);
        xfer(1'b0, 18'h3_FFFF, 2'b11, 16'h0000);
        `CHK(q, 16'hA5C3)
    endtask
    task automatic t_bytes;
        xfer(1'b1, 18'h0_0000, 2'b11, 16'h1234);
        xfer(1'b1, 18'h0_0000, 2'b01, 16'h55AB);
        xfer(1'b1, 18'h0_0000, 2'b10, 16'hCD77);
        xfer(1'b0, 18'h0_0000, 2'b11, 16'h0000);
        `CHK(q, 16'hCDAB)
        xfer(1'b0, 18'h0_0000, 2'b01, 16'h0000);
        `CHK(q, 16'h00AB)
        xfer(1'b0, 18'h0_0000, 2'b10, 16'h0000);
        `CHK(q, 16'hCD00)
    endtask
    task automatic t_ignore;
        logic idle;
        idle = 1'b1;
        xfer(1'b1, 18'h0_0000, 2'b00, 16'hFFFF);
        repeat (6)
        begin
            idle &= (mem_strobe === asr_pkg::STROBE_IDLE);
            @(posedge clk) #1;
        end
        xfer(1'b0, 18'h0_0000, 2'b11, 16'h0000);
        `CHK({idle, q}, {1'b1, 16'hCDAB})
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        {rst, clk_en, req_valid, req, n_mismatch, cmp_count} = '0;
        rst = 1'b1;
        clk_en = 1'b1;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        `CHK({mem_strobe, mem_dq_oe_n}, {asr_pkg::STROBE_IDLE, 2'b11})
        t_full;
        t_bytes;
        t_ignore;
        stop_test;
    end
endmodule

// *** dv/asr_sram_model.sv ***
`timescale 1ns/10ps
module asr_sram_model (
    input  wire logic [asr_pkg::ADDR_W-1:0] addr,
    input  wire asr_pkg::asr_strobe_t       strobe,
    input  wire logic [asr_pkg::DATA_W-1:0] dq_out,
    input  wire logic [1:0]                 dq_oe_n,
    output logic [asr_pkg::DATA_W-1:0]      dq_in
);
    logic [15:0] mem [0:262143];
    logic [1:0]  lane;
    logic [1:0]  rd;
    logic        wr;
    always_comb
    begin
        lane = ~{strobe.upper_lane_sel_n, strobe.lower_lane_sel_n};
        wr   = !strobe.chip_sel_n && !strobe.write_n;
        rd   = (!strobe.chip_sel_n && strobe.write_n && !strobe.out_en_n) ? lane : 2'b00;
    end
    // Store only inside the overlap; a lane left undriven stores unknown
    always @*
        if (wr)
            for (int i = 0; i < 2; i++)
                if (lane[i])
                    mem[addr][8*i+:8] = dq_oe_n[i] ? 8'hxx : dq_out[8*i+:8];
    // A floating lane shows the inverse of the stored byte
    always_comb
        for (int i = 0; i < 2; i++)
            dq_in[8*i+:8] = rd[i] ? mem[addr][8*i+:8] : ~mem[addr][8*i+:8];
endmodule

// *** verilog/asr_ctrl.sv ***
`timescale 1ns/10ps
// Behaviour
// - Data setup and hold referenced to the write-ending strobe edge.
// - Controller never drives data while device drives.
// - Address-controlled read: selects held low, data valid 45 ns later.
// - Lane select held low 40 ns before write ends.
// - Address valid before or with chip and lane selects falling.
module asr_ctrl #(
    parameter int RD_CYCLES   = asr_pkg::RD_CYC,
    parameter int WR_CYCLES   = asr_pkg::WR_CYC,
    parameter int TURN_CYCLES = asr_pkg::TURN_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       clk_en,
    input  wire logic                       req_valid,
    output logic                            req_ready,
    input  wire asr_pkg::asr_req_t          req,
    output logic                            rsp_valid,
    output logic [asr_pkg::DATA_W-1:0]      rsp_rdata,
    output logic [asr_pkg::ADDR_W-1:0]      mem_addr,
    output asr_pkg::asr_strobe_t            mem_strobe,
    input  wire logic [asr_pkg::DATA_W-1:0] mem_dq_in,
    output logic [asr_pkg::DATA_W-1:0]      mem_dq_out,
    output logic [1:0]                      mem_dq_oe_n
);

    typedef enum logic [2:0] {
        ASR_IDLE,
        ASR_SETUP,
        ASR_READ,
        ASR_WRITE,
        ASR_HOLD,
        ASR_TURN
    } asr_state_t;

    asr_state_t                  state_reg;
    logic [asr_pkg::CNT_W-1:0]   cnt_reg;
    asr_pkg::asr_req_t           cur_reg;

    // High on the final cycle of a phase that lasts n cycles
    function automatic logic phase_last(
        input logic [asr_pkg::CNT_W-1:0] cnt,
        input int                        n
    );
        return cnt == (asr_pkg::CNT_W)'(n - 1);
    endfunction

    assign req_ready = (state_reg == ASR_IDLE);

    // Sequencer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= ASR_IDLE;
            cnt_reg   <= '0;
        end
        else if (clk_en)
        begin
            case (state_reg)
                ASR_IDLE:
                begin
                    // Lane-less request is no access
                    if (req_valid && (req.lane_en != 2'h0))
                        state_reg <= ASR_SETUP;
                end
                ASR_SETUP:
                begin
                    // Address settles one cycle before any strobe falls
                    cnt_reg   <= '0;
                    state_reg <= cur_reg.write ? ASR_WRITE : ASR_READ;
                end
                ASR_READ:
                begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (phase_last(cnt_reg, RD_CYCLES))
                    begin
                        cnt_reg   <= '0;
                        state_reg <= ASR_TURN;
                    end
                end
                ASR_WRITE:
                begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (phase_last(cnt_reg, WR_CYCLES))
                        state_reg <= ASR_HOLD;
                end
                ASR_HOLD:
                begin
                    // Data held one cycle past the ending edge
                    cnt_reg   <= '0;
                    state_reg <= ASR_TURN;
                end
                ASR_TURN:
                begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (phase_last(cnt_reg, TURN_CYCLES))
                    begin
                        cnt_reg   <= '0;
                        state_reg <= ASR_IDLE;
                    end
                end
                default:
                    state_reg <= ASR_IDLE;
            endcase
        end
    end

    // Request capture
    always_ff @(posedge clk)
    begin
        if (rst)
            cur_reg <= '0;
        else if (clk_en && req_valid && req_ready)
            cur_reg <= req;
    end

    // Pin drive
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mem_addr    <= '0;
            mem_strobe  <= asr_pkg::STROBE_IDLE;
            mem_dq_out  <= '0;
            mem_dq_oe_n <= 2'h3;
        end
        else if (clk_en)
        begin
            mem_strobe  <= asr_pkg::STROBE_IDLE;
            mem_dq_oe_n <= 2'h3;
            if (state_reg == ASR_IDLE && req_valid)
                mem_addr <= req.addr;
            case (state_reg)
                ASR_SETUP:
                begin
                    if (cur_reg.write)
                    begin
                        // Strobes fall together; the write opens on the overlap
                        mem_strobe.chip_sel_n       <= 1'b0;
                        mem_strobe.write_n          <= 1'b0;
                        mem_strobe.upper_lane_sel_n <= ~cur_reg.lane_en[1];
                        mem_strobe.lower_lane_sel_n <= ~cur_reg.lane_en[0];
                        mem_dq_out  <= cur_reg.wdata;
                        // Device floats while write strobe is low
                        mem_dq_oe_n <= ~cur_reg.lane_en;
                    end
                    else
                    begin
                        mem_strobe.chip_sel_n       <= 1'b0;
                        mem_strobe.out_en_n         <= 1'b0;
                        mem_strobe.upper_lane_sel_n <= ~cur_reg.lane_en[1];
                        mem_strobe.lower_lane_sel_n <= ~cur_reg.lane_en[0];
                    end
                end
                ASR_READ:
                begin
                    // Hold off bus while device may drive
                    mem_dq_oe_n <= 2'h3;
                    if (!phase_last(cnt_reg, RD_CYCLES))
                    begin
                        mem_strobe.chip_sel_n       <= 1'b0;
                        mem_strobe.out_en_n         <= 1'b0;
                        mem_strobe.upper_lane_sel_n <= ~cur_reg.lane_en[1];
                        mem_strobe.lower_lane_sel_n <= ~cur_reg.lane_en[0];
                    end
                end
                ASR_WRITE:
                begin
                    mem_dq_oe_n <= ~cur_reg.lane_en;
                    if (!phase_last(cnt_reg, WR_CYCLES))
                    begin
                        mem_strobe.chip_sel_n       <= 1'b0;
                        mem_strobe.write_n          <= 1'b0;
                        mem_strobe.upper_lane_sel_n <= ~cur_reg.lane_en[1];
                        mem_strobe.lower_lane_sel_n <= ~cur_reg.lane_en[0];
                    end
                    // All strobes rise together; data stays driven one more cycle
                end
                default:
                    mem_dq_oe_n <= 2'h3;
            endcase
        end
    end

    // Read capture on the last cycle before strobes rise, lanes merged
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end
        else if (clk_en)
        begin
            rsp_valid <= 1'b0;
            if (state_reg == ASR_READ && phase_last(cnt_reg, RD_CYCLES))
            begin
                rsp_valid <= 1'b1;
                rsp_rdata <= {cur_reg.lane_en[1] ? mem_dq_in[asr_pkg::DATA_W-1:asr_pkg::BYTE_W]
                                                 : {asr_pkg::BYTE_W{1'b0}},
                              cur_reg.lane_en[0] ? mem_dq_in[asr_pkg::BYTE_W-1:0]
                                                 : {asr_pkg::BYTE_W{1'b0}}};
            end
        end
    end

endmodule

// *** verilog/asr_pkg.sv ***
package asr_pkg;

    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int CLK_PERIOD_PS = 5000;

    // Device timing figures, ns (fastest grade)
    localparam int T_RC_NS   = 45;
    localparam int T_AA_NS   = 45;
    localparam int T_DOE_NS  = 25;
    localparam int T_OHA_NS  = 10;
    localparam int T_HZ_NS   = 20;
    localparam int T_WC_NS   = 45;
    localparam int T_BW_NS   = 40;
    localparam int T_SD_NS   = 25;
    localparam int T_PWE_NS  = 35;
    localparam int T_LZWE_NS = 10;

    // Least times round up to whole cycles
    function automatic int min_cycles(input int t_ns);
        int c;
        c = (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int RD_CYC   = min_cycles(T_RC_NS > T_AA_NS ? T_RC_NS : T_AA_NS) + 1;
    localparam int WR_CYC   = min_cycles(T_BW_NS);
    localparam int TURN_CYC = min_cycles(T_HZ_NS > T_LZWE_NS ? T_HZ_NS : T_LZWE_NS);
    localparam int CNT_W    = 8;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [1:0]        lane_en;
        logic [DATA_W-1:0] wdata;
    } asr_req_t;

    typedef struct packed {
        logic chip_sel_n;
        logic write_n;
        logic out_en_n;
        logic upper_lane_sel_n;
        logic lower_lane_sel_n;
    } asr_strobe_t;

    localparam asr_strobe_t STROBE_IDLE = 5'h1F;

endpackage
